// file: logic/dauw_pkg.sv
package dauw_pkg;

  localparam int DAC_W       = 12;
  localparam int WIDE_DAC_W  = 16;
  localparam int DATA_W      = 16;
  localparam int CNT_W       = 24;
  localparam int FIFO_DEPTH  = 2048;
  localparam int PEND_W      = 2;

  localparam logic [CNT_W-1:0]  CNT_ONE     = 24'h000001;
  localparam logic [PEND_W-1:0] PEND_ONE    = 2'h1;
  localparam logic [PEND_W-1:0] PEND_TWO    = 2'h2;
  localparam logic [WIDE_DAC_W-1:0] ZERO_CODE = 16'h0000;

  typedef struct packed {
    logic timed;
    logic bipolar;
    logic ext_ref;
    logic reglitch;
  } dauw_chan_cfg_t;

  typedef struct packed {
    dauw_chan_cfg_t b;
    dauw_chan_cfg_t a;
  } dauw_cfg_t;

  localparam dauw_cfg_t CFG_RESET = 8'h00;

  typedef struct packed {
    logic [CNT_W-1:0] interval;
    logic [CNT_W-1:0] updates;
    logic [CNT_W-1:0] repeats;
  } dauw_seq_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } dauw_state_t;

endpackage

// file: logic/dauw_top.sv
`timescale 1ns/1ns
`default_nettype none

module dauw_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 2048,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready,
  input  wire logic         keep,
  input  wire logic         retransmit
);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] base;
  logic [AW:0]   count;
  logic [AW:0]   loaded;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;
  wire [AW:0]    next_count = retransmit ? loaded : count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  wire [AW:0]    next_loaded = keep ? loaded + {{AW{1'b0}}, push} : next_count;
  // In retransmit mode, slots already read stay reserved so the waveform can be replayed.
  wire [AW:0]    next_occ = keep ? next_loaded : next_count;

  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      base      <= '0;
      count     <= '0;
      loaded    <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= wr_ptr + AW'(push);
      rd_ptr    <= retransmit ? base : rd_ptr + AW'(pop);
      base      <= keep ? base : rd_ptr + AW'(pop);
      count     <= next_count;
      loaded    <= next_loaded;
      in_ready  <= next_occ < (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end
endmodule

// Behaviour
// - Two output channels, 12-bit codes by default, 16-bit in the wide variant.
// - After power-up each DAC code is the zero-volt code before any write.
// - Unipolar channel passes its written code as straight binary.
// - Bipolar channel treats its written code as two's complement.
// - Each channel independently selects immediate or timed update.
// - Immediate mode holds the update strobe low so writes appear at once.
// - Timed mode changes the output only on that channel's update strobe.
// - Direct-data writes load the first buffer stage without the timing engine.
// - A software update command asserts the channel's active-low update strobe.
// - A 24-bit interval counter produces update pulses routed to the strobes.
// - A 24-bit update counter counts updates; its load sets the buffer length.
// - A buffer counter sets how often one buffer repeats in a sequence.
// - After each update pulse the next sample moves into the target first stage.
// - The real FIFO takes writes while not full and gives reads while not empty.
// - An empty real FIFO stalls a due transfer until new data arrives.
// - Virtual FIFO clears its full flag when an update needs a transfer.
// - Virtual FIFO passes the word straight to the DAC, then sets full again.
// - The full flag is offered to the host as its request condition.
// - Retransmit mode rewinds an emptied FIFO so the same waveform repeats.
// - With both DACs running and INTERLEAVE set, alternate samples go to alternate DACs; without INTERLEAVE all go to DAC A, or to DAC B if only B runs.
// - Polarity, reference select and reglitch come from the configuration register.
module dauw_top
  import dauw_pkg::*;
#(
  parameter int         DAC_W_P      = dauw_pkg::DAC_W,
  parameter int         DEPTH        = dauw_pkg::FIFO_DEPTH,
  parameter bit         VIRTUAL_FIFO = 1'b0
) (
  input  wire logic                     CLK,
  input  wire logic                     NRST,
  input  wire logic                     CFG_WR,
  input  wire dauw_pkg::dauw_cfg_t      CFG_IN,
  input  wire logic                     DIRECT_WR_A,
  input  wire logic                     DIRECT_WR_B,
  input  wire logic [dauw_pkg::DATA_W-1:0] DIRECT_DATA,
  input  wire logic                     SW_UPDATE_A,
  input  wire logic                     SW_UPDATE_B,
  input  wire dauw_pkg::dauw_seq_t      SEQ,
  input  wire logic                     SEQ_START,
  input  wire logic [1:0]               WAVE_EN,
  input  wire logic                     INTERLEAVE,
  input  wire logic                     RETRANSMIT_EN,
  input  wire logic                     FIFO_WR_VALID,
  input  wire logic [dauw_pkg::DATA_W-1:0] FIFO_WR_DATA,
  output logic                          FIFO_WR_READY,
  output logic                          FIFO_FULL,
  output logic                          FIFO_EMPTY,
  output logic [DAC_W_P-1:0]            DAC_A_CODE,
  output logic [DAC_W_P-1:0]            DAC_B_CODE,
  output logic                          DAC_A_UPDATE_STROBE_N,
  output logic                          DAC_B_UPDATE_STROBE_N,
  output logic [1:0]                    EXTERNAL_REFERENCE_SEL,
  output logic [1:0]                    REGLITCH_EN,
  output logic                          SEQ_BUSY
);
  import dauw_pkg::*;

  dauw_cfg_t         output_config_reg;
  dauw_state_t       state;
  logic [CNT_W-1:0]  update_interval_counter;
  logic [CNT_W-1:0]  update_count_counter;
  logic [CNT_W-1:0]  buffer_repeat_counter;
  logic [PEND_W-1:0] pending;
  logic              dest_b;
  logic              vfull;

  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;

  // Bipolar codes are two's complement; the converter wants offset binary.
  function automatic logic [DAC_W_P-1:0] to_dac(input logic [DATA_W-1:0] d,
                                                input logic bip);
    logic [DAC_W_P-1:0] c;
    c = d[DAC_W_P-1:0];
    to_dac = bip ? {~c[DAC_W_P-1], c[DAC_W_P-2:0]} : c;
  endfunction

  wire running     = state == ST_RUN;
  wire upd_pulse   = running && update_interval_counter <= CNT_ONE;
  wire uc_expire   = upd_pulse && update_count_counter <= CNT_ONE;
  wire bc_expire   = uc_expire && buffer_repeat_counter <= CNT_ONE;
  wire both_wave   = INTERLEAVE && WAVE_EN == 2'b11;
  wire [PEND_W-1:0] need = (WAVE_EN == 2'b00) ? '0 : (both_wave ? PEND_TWO : PEND_ONE);
  wire src_valid   = VIRTUAL_FIFO ? (FIFO_WR_VALID && !vfull) : fifo_out_valid;
  wire take        = pending != '0 && src_valid;
  wire [DATA_W-1:0] src_data = VIRTUAL_FIFO ? FIFO_WR_DATA : fifo_out_data;
  wire take_b      = both_wave ? dest_b : !WAVE_EN[0];
  wire [PEND_W-1:0] next_pending = pending - PEND_W'(take) + (upd_pulse ? need : '0);
  wire retransmit  = !VIRTUAL_FIFO && RETRANSMIT_EN && pending != '0
                     && !fifo_out_valid;
  wire ld_a        = DIRECT_WR_A || (take && !take_b);
  wire ld_b        = DIRECT_WR_B || (take && take_b);
  wire [DATA_W-1:0] data_a = DIRECT_WR_A ? DIRECT_DATA : src_data;
  wire [DATA_W-1:0] data_b = DIRECT_WR_B ? DIRECT_DATA : src_data;
  // Immediate mode keeps the strobe low, making the second stage transparent.
  wire next_strobe_a_n = !(!output_config_reg.a.timed || SW_UPDATE_A
                           || (upd_pulse && WAVE_EN[0]));
  wire next_strobe_b_n = !(!output_config_reg.b.timed || SW_UPDATE_B
                           || (upd_pulse && WAVE_EN[1]));
  // Clearing for a new update wins over the refill of the previous one.
  wire next_vfull  = (next_pending != '0) ? 1'b0 : ((take || vfull) ? 1'b1 : vfull);

  dauw_fifo #(
    .W     (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk        (CLK),
    .nrst       (NRST),
    .in_valid   (FIFO_WR_VALID && !VIRTUAL_FIFO),
    .in_data    (FIFO_WR_DATA),
    .in_ready   (fifo_in_ready),
    .out_valid  (fifo_out_valid),
    .out_data   (fifo_out_data),
    .out_ready  (take && !VIRTUAL_FIFO),
    .keep       (RETRANSMIT_EN),
    .retransmit (retransmit)
  );

  assign FIFO_WR_READY = VIRTUAL_FIFO ? !vfull : fifo_in_ready;
  assign FIFO_FULL     = VIRTUAL_FIFO ? vfull : !fifo_in_ready;
  assign FIFO_EMPTY    = VIRTUAL_FIFO ? 1'b0 : !fifo_out_valid;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      output_config_reg <= CFG_RESET;
    end else if (CFG_WR) begin
      output_config_reg <= CFG_IN;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      EXTERNAL_REFERENCE_SEL <= 2'h0;
      REGLITCH_EN            <= 2'h0;
    end else begin
      EXTERNAL_REFERENCE_SEL <= {output_config_reg.b.ext_ref, output_config_reg.a.ext_ref};
      REGLITCH_EN <= {output_config_reg.b.reglitch, output_config_reg.a.reglitch};
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      DAC_A_CODE <= ZERO_CODE[DAC_W_P-1:0];
      DAC_B_CODE <= ZERO_CODE[DAC_W_P-1:0];
    end else begin
      if (ld_a) begin
        DAC_A_CODE <= to_dac(data_a, output_config_reg.a.bipolar);
      end
      if (ld_b) begin
        DAC_B_CODE <= to_dac(data_b, output_config_reg.b.bipolar);
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      DAC_A_UPDATE_STROBE_N <= 1'b0;
      DAC_B_UPDATE_STROBE_N <= 1'b0;
    end else begin
      DAC_A_UPDATE_STROBE_N <= next_strobe_a_n;
      DAC_B_UPDATE_STROBE_N <= next_strobe_b_n;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state                   <= ST_IDLE;
      update_interval_counter <= '0;
      update_count_counter    <= '0;
      buffer_repeat_counter   <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (SEQ_START) begin
            state                   <= ST_RUN;
            update_interval_counter <= SEQ.interval;
            update_count_counter    <= SEQ.updates;
            buffer_repeat_counter   <= SEQ.repeats;
          end
        end
        ST_RUN: begin
          update_interval_counter <= upd_pulse ? SEQ.interval : update_interval_counter - CNT_ONE;
          if (upd_pulse) begin
            update_count_counter <= uc_expire ? SEQ.updates : update_count_counter - CNT_ONE;
          end
          if (uc_expire) begin
            buffer_repeat_counter <= buffer_repeat_counter - CNT_ONE;
          end
          if (bc_expire) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pending  <= '0;
      dest_b   <= 1'b0;
      vfull    <= 1'b1;
      SEQ_BUSY <= 1'b0;
    end else begin
      pending  <= next_pending;
      dest_b   <= (!running && SEQ_START) ? 1'b0 : dest_b ^ (take && both_wave);
      vfull    <= VIRTUAL_FIFO ? next_vfull : 1'b1;
      SEQ_BUSY <= (state == ST_IDLE) ? SEQ_START : !bc_expire;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence s_direct_a;
    DIRECT_WR_A && !CFG_WR;
  endsequence

  property p_immediate;
    !output_config_reg.a.timed && !CFG_WR |=> !DAC_A_UPDATE_STROBE_N [*2];
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate strobe not low");

  property p_timed_hold;
    output_config_reg.b.timed && !SW_UPDATE_B && !(upd_pulse && WAVE_EN[1])
      |=> DAC_B_UPDATE_STROBE_N;
  endproperty
  a_timed_hold: assert property (p_timed_hold) else $error("timed strobe fired");

  property p_sw_update;
    SW_UPDATE_A |=> !DAC_A_UPDATE_STROBE_N;
  endproperty
  a_sw_update: assert property (p_sw_update) else $error("software update lost");

  property p_unipolar;
    s_direct_a ##0 !output_config_reg.a.bipolar
      |=> DAC_A_CODE == $past(DIRECT_DATA[DAC_W_P-1:0]);
  endproperty
  a_unipolar: assert property (p_unipolar) else $error("unipolar code wrong");

  property p_bipolar;
    s_direct_a ##0 output_config_reg.a.bipolar
      |=> DAC_A_CODE[DAC_W_P-1] != $past(DIRECT_DATA[DAC_W_P-1]);
  endproperty
  a_bipolar: assert property (p_bipolar) else $error("bipolar msb not flipped");

  property p_interval;
    upd_pulse && SEQ.interval > CNT_ONE |=> !upd_pulse;
  endproperty
  a_interval: assert property (p_interval) else $error("early update pulse");

  property p_stall;
    !VIRTUAL_FIFO && !fifo_out_valid |-> !take ##1 ($stable(DAC_B_CODE) || $past(DIRECT_WR_B));
  endproperty
  a_stall: assert property (p_stall) else $error("transfer from empty fifo");

  property p_vclear;
    VIRTUAL_FIFO && upd_pulse && WAVE_EN != 2'b00 |=> !FIFO_FULL;
  endproperty
  a_vclear: assert property (p_vclear) else $error("virtual full not cleared");

  property p_end;
    bc_expire |=> state == ST_IDLE && !SEQ_BUSY;
  endproperty
  a_end: assert property (p_end) else $error("sequence did not end");

  property p_alternate;
    take && both_wave |=> dest_b != $past(dest_b);
  endproperty
  a_alternate: assert property (p_alternate) else $error("interleave not alternating");

  property p_direct_b;
    DIRECT_WR_B && !output_config_reg.b.bipolar
      |=> DAC_B_CODE == $past(DIRECT_DATA[DAC_W_P-1:0]);
  endproperty
  a_direct_b: assert property (p_direct_b) else $error("direct write b lost");

  property p_transfer_a;
    take && !take_b && !DIRECT_WR_A && !output_config_reg.a.bipolar
      |=> DAC_A_CODE == $past(src_data[DAC_W_P-1:0]);
  endproperty
  a_transfer_a: assert property (p_transfer_a) else $error("sample lost on a");

  property p_ucount;
    upd_pulse && !uc_expire
      |=> update_count_counter == $past(update_count_counter) - CNT_ONE;
  endproperty
  a_ucount: assert property (p_ucount) else $error("update count not stepped");

  property p_vrefill;
    VIRTUAL_FIFO && take && !upd_pulse && pending == PEND_ONE |=> FIFO_FULL;
  endproperty
  a_vrefill: assert property (p_vrefill) else $error("virtual full not set");

  property p_retransmit;
    retransmit && u_fifo.loaded != '0 |=> fifo_out_valid;
  endproperty
  a_retransmit: assert property (p_retransmit) else $error("retransmit no data");

  property p_cfg_copy;
    CFG_WR |=> ##1 REGLITCH_EN == $past({CFG_IN.b.reglitch, CFG_IN.a.reglitch}, 2)
      && EXTERNAL_REFERENCE_SEL == $past({CFG_IN.b.ext_ref, CFG_IN.a.ext_ref}, 2);
  endproperty
  a_cfg_copy: assert property (p_cfg_copy) else $error("config copy wrong");

endmodule

`default_nettype wire

// file: testbench/dauw_dac_model.sv
`timescale 1ns/1ns
`default_nettype none

// The second stage loads from the code lines at each edge while the update strobe is low.
module dauw_dac_model #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] code,
  input  wire logic         strobe_n,
  output logic [W-1:0]      level
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level <= '0;
    end else if (!strobe_n) begin
      level <= code;
    end
  end
endmodule

`default_nettype wire

// file: testbench/tb_dual_dac_update_and_waveform.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end

module tb_dual_dac_update_and_waveform;
  import dauw_pkg::*;
  logic        clk, nrst, cfg_wr, wr_a, wr_b, upd_a, upd_b, start, start_v;
  logic        ilv, rtx, fv, fv_v, fready, ffull, fempty, stb_a, stb_b, busy, vfull;
  dauw_cfg_t   cfg;
  dauw_seq_t   seq;
  logic [1:0]  wave_en, xref, rgl;
  logic [15:0] ddata, fd;
  logic [11:0] code_a, code_b, pa, pb, vcode_a, la, lb;
  logic [11:0] qa[$], qb[$];
  int          err_count, cmp_count, sa, sb, cyc, n;

  dauw_top #(.DEPTH(16)) DUT (
    .CLK(clk), .NRST(nrst), .CFG_WR(cfg_wr), .CFG_IN(cfg), .DIRECT_WR_A(wr_a),
    .DIRECT_WR_B(wr_b), .DIRECT_DATA(ddata), .SW_UPDATE_A(upd_a), .SW_UPDATE_B(upd_b),
    .SEQ(seq), .SEQ_START(start), .WAVE_EN(wave_en), .INTERLEAVE(ilv), .RETRANSMIT_EN(rtx),
    .FIFO_WR_VALID(fv), .FIFO_WR_DATA(fd), .FIFO_WR_READY(fready), .FIFO_FULL(ffull),
    .FIFO_EMPTY(fempty), .DAC_A_CODE(code_a), .DAC_B_CODE(code_b),
    .DAC_A_UPDATE_STROBE_N(stb_a), .DAC_B_UPDATE_STROBE_N(stb_b),
    .EXTERNAL_REFERENCE_SEL(xref), .REGLITCH_EN(rgl), .SEQ_BUSY(busy));

  dauw_top #(.DEPTH(16), .VIRTUAL_FIFO(1'b1)) DUT_V (
    .CLK(clk), .NRST(nrst), .CFG_WR(cfg_wr), .CFG_IN(cfg), .DIRECT_WR_A(wr_a),
    .DIRECT_WR_B(wr_b), .DIRECT_DATA(ddata), .SW_UPDATE_A(upd_a), .SW_UPDATE_B(upd_b),
    .SEQ(seq), .SEQ_START(start_v), .WAVE_EN(wave_en), .INTERLEAVE(ilv), .RETRANSMIT_EN(rtx),
    .FIFO_WR_VALID(fv_v), .FIFO_WR_DATA(fd), .FIFO_WR_READY(), .FIFO_FULL(vfull),
    .FIFO_EMPTY(), .DAC_A_CODE(vcode_a), .DAC_B_CODE(), .DAC_A_UPDATE_STROBE_N(),
    .DAC_B_UPDATE_STROBE_N(), .EXTERNAL_REFERENCE_SEL(), .REGLITCH_EN(), .SEQ_BUSY());

  dauw_dac_model #(.W(12)) DAC_A (.clk(clk), .nrst(nrst), .code(code_a), .strobe_n(stb_a),
    .level(pa));
  dauw_dac_model #(.W(12)) DAC_B (.clk(clk), .nrst(nrst), .code(code_b), .strobe_n(stb_b),
    .level(pb));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic dwr(input logic b, input logic [15:0] d);
    ddata = d; wr_a = !b; wr_b = b; tick(1); wr_a = 1'b0; wr_b = 1'b0;
  endtask

  task automatic setcfg(input dauw_cfg_t c);
    cfg = c; cfg_wr = 1'b1; tick(1); cfg_wr = 1'b0; tick(2);
  endtask

  // Holds the write request up across consecutive words; callers keep within free space.
  task automatic pushn(input logic [15:0] base, input int k);
    fv = 1'b1;
    for (int i = 0; i < k; i++) begin
      fd = base + 16'(i); tick(1);
    end
    fv = 1'b0;
  endtask

  task automatic run(input logic [23:0] iv, input logic [23:0] u, input logic [23:0] r,
                     input bit v);
    seq = '{interval: iv, updates: u, repeats: r};
    start = !v; start_v = v; tick(1); start = 1'b0; start_v = 1'b0;
  endtask

  task automatic waitbusy();
    for (n = 0; n < 2000 && busy !== 1'b0; n++) tick(1);
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Records every new code on each channel and counts strobe-low cycles.
  always @(posedge clk) begin
    cyc++;
    if (nrst && !stb_a) sa++;
    if (nrst && !stb_b) sb++;
    if (nrst && code_a !== la) qa.push_back(code_a);
    if (nrst && code_b !== lb) qb.push_back(code_b);
    la = code_a; lb = code_b;
    if (cyc == 3000) begin
      err_count++; report_and_stop();
    end
  end

  initial begin
    nrst = 1'b0; cfg_wr = 1'b0; wr_a = 1'b0; wr_b = 1'b0; upd_a = 1'b0; upd_b = 1'b0;
    start = 1'b0; start_v = 1'b0; ilv = 1'b0; rtx = 1'b0; fv = 1'b0; fv_v = 1'b0;
    cfg = CFG_RESET; seq = '0; wave_en = 2'h0; ddata = 16'h0000; fd = 16'h0000;
    la = 12'h000; lb = 12'h000; err_count = 0; cmp_count = 0; sa = 0; sb = 0; cyc = 0;
    tick(12); nrst = 1'b1; tick(1);
    `CHK("code_a", 12'h000, code_a)
    `CHK("empty", 1'b1, fempty)
    `CHK("vfull", 1'b1, vfull)
    dwr(1'b0, 16'h0123); `CHK("code_a", 12'h123, code_a)
    tick(1); `CHK("dac_a", 12'h123, pa)
    setcfg(8'h0F); `CHK("xref", 2'h1, xref)
    `CHK("reglitch", 2'h1, rgl)
    dwr(1'b0, 16'h07FF); `CHK("code_a", 12'hFFF, code_a)
    sa = 0; tick(3); `CHK("dac_a", 12'h123, pa)
    dwr(1'b1, 16'h0456); tick(1); `CHK("dac_b", 12'h456, pb)
    upd_a = 1'b1; tick(1); upd_a = 1'b0; tick(1);
    `CHK("strobes_a", 1, sa)
    `CHK("dac_a", 12'hFFF, pa)
    setcfg(8'h88); wave_en = 2'h3; ilv = 1'b1;
    pushn(16'h0100, 16); `CHK("full", 1'b1, ffull)
    `CHK("ready", 1'b0, fready)
    qa.delete(); qb.delete(); sa = 0; sb = 0;
    run(24'd4, 24'd2, 24'd2, 1'b0); waitbusy(); tick(6);
    `CHK("strobes_a", 4, sa)
    `CHK("strobes_b", 4, sb)
    `CHK("busy_len", 1'b1, (n >= 16 && n <= 18))
    `CHK("count_a", 4, qa.size())
    for (int i = 0; i < 4; i++) begin
      `CHK("sample_a", 12'(12'h100 + 2 * i), qa[i])
      `CHK("sample_b", 12'(12'h101 + 2 * i), qb[i])
    end
    `CHK("empty", 1'b0, fempty)
    setcfg(8'h00); wave_en = 2'h1; ilv = 1'b0; qa.delete();
    run(24'd10, 24'd10, 24'd1, 1'b0);
    for (n = 0; n < 300 && fempty !== 1'b1; n++) tick(1);
    tick(12); `CHK("code_a", 12'h10F, code_a)
    pushn(16'h0110, 2); waitbusy(); tick(4);
    `CHK("count_a", 10, qa.size())
    for (int i = 0; i < 10; i++) `CHK("sample_a", 12'(12'h108 + i), qa[i])
    nrst = 1'b0; tick(3); `CHK("code_a", 12'h000, code_a)
    nrst = 1'b1; tick(1); rtx = 1'b1; pushn(16'h00A0, 3); qa.delete();
    run(24'd3, 24'd6, 24'd1, 1'b0); waitbusy(); tick(4);
    for (int i = 0; i < 6; i++) `CHK("replay_a", 12'(12'h0A0 + i % 3), qa[i])
    rtx = 1'b0;
    run(24'd5, 24'd2, 24'd1, 1'b1);
    for (int k = 0; k < 2; k++) begin
      // The host paces its words on the full flag alone.
      for (n = 0; n < 50 && vfull !== 1'b0; n++) tick(1);
      `CHK("vfull_low", 1'b0, vfull)
      fd = 16'h0321 + 16'(k); fv_v = 1'b1; tick(1); fv_v = 1'b0; tick(1);
      `CHK("vfull", 1'b1, vfull)
      `CHK("vcode_a", 12'(12'h321 + k), vcode_a)
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
